// ===== core/bpss_core.sv
// Summary of operation
// - pwm cycle: low gate on until peak trip, then one clock off
// - low-side gate set on the clock edge after it is off
// - peak trip swaps low gate to high drive
// - supply undervoltage inhibits all switching
// - undervoltage drops power-good, gates, discharges soft-start
// - enable plus stable reference enters initialization
// - discharge switch held during initialization
// - charge soft-start only with valid reference
// - switching starts when comp and soft-start ready
// - enable or reference low forces full shutdown
// - config selects phase count and overvoltage enable
`include "bpss_consts.svh"
module bpss_core
   import bpss_pkg::*;
(
   input wire logic clk_i, // switching clock
   input wire logic nrst_i, // power-on reset
   input wire bpss_sense_type sense_i, // comparator outputs
   input wire logic [`BPSS_CFG_W-1:0] config_select_pin_i, // config code
   output logic low_side_gate_o,
   output logic high_side_drive_o,
   output logic power_good_out_o,
   output logic share_current_neg_o,
   output logic ss_charge_o, // soft-start current source on
   output logic ss_discharge_o, // soft-start discharge switch on
   output logic comp_discharge_o, // compensation node pull-down
   output logic ovp_enable_o, // latched overvoltage enable
   output logic [1:0] phase_sel_o // latched phase selection
);
   // ***************************************
   // reset release and input synchronisers
   // ***************************************
   logic rst_meta_ff; // first stage, read only by second
   logic rst_n_ff; // released reset copy
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end
   bpss_sense_type sns_meta_ff; // first stage
   bpss_sense_type sns_ff; // usable copy
   logic [`BPSS_CFG_W-1:0] cfg_meta_ff;
   logic [`BPSS_CFG_W-1:0] cfg_ff;
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         sns_meta_ff <= '0;
         sns_ff <= '0;
         cfg_meta_ff <= '0;
         cfg_ff <= '0;
      end else begin
         sns_meta_ff <= sense_i;
         sns_ff <= sns_meta_ff;
         cfg_meta_ff <= config_select_pin_i;
         cfg_ff <= cfg_meta_ff;
      end
   end
   // ***************************************
   // fault decode
   // ***************************************
   logic uv_fault; // supply below lockout
   logic en_fault; // enable or reference dropped
   assign uv_fault = !sns_ff.drv_ok;
   assign en_fault = sns_ff.en_off || sns_ff.ref_low;
   // ***************************************
   // sequencer
   // ***************************************
   bpss_state_type state_ff;
   bpss_state_type nxt_state;
   logic [`BPSS_INIT_W-1:0] init_cnt_ff; // initialization timer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         BPSS_OFF: begin
            // wait for enable and reference
            if (sns_ff.drv_ok && sns_ff.en_on && sns_ff.ref_ok) begin
               nxt_state = BPSS_INIT;
            end
         end
         BPSS_INIT: begin
            // reference must be valid to charge
            if (init_cnt_ff == `BPSS_INIT_CYCLES && sns_ff.ref_ok) begin
               nxt_state = BPSS_SOFT;
            end
         end
         BPSS_SOFT: begin
            if (sns_ff.start_ok) begin
               nxt_state = BPSS_RUN;
            end
         end
         BPSS_RUN: begin
            nxt_state = BPSS_RUN;
         end
         default: nxt_state = BPSS_OFF;
      endcase
      // any fault returns to off, restart is full sequence
      if (uv_fault || en_fault) begin
         nxt_state = BPSS_OFF;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff <= BPSS_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // init counter runs only in init
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         init_cnt_ff <= '0;
      end else if (state_ff != BPSS_INIT) begin
         init_cnt_ff <= '0;
      end else if (init_cnt_ff != `BPSS_INIT_CYCLES) begin
         init_cnt_ff <= init_cnt_ff + 1'b1;
      end
   end
   // ***************************************
   // configuration latch
   // ***************************************
   // sampled at end of init; codes beyond table fall back to single
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ovp_enable_o <= 1'b0;
         phase_sel_o <= BPSS_PH_SINGLE;
      end else if (state_ff == BPSS_INIT && init_cnt_ff == `BPSS_INIT_CYCLES) begin
         ovp_enable_o <= !cfg_ff[0];
         unique case (cfg_ff[2:1])
            2'b00: phase_sel_o <= BPSS_PH_DUALQUAD;
            2'b01: phase_sel_o <= BPSS_PH_SINGLE;
            2'b10: phase_sel_o <= BPSS_PH_TRIPLE;
            default: phase_sel_o <= BPSS_PH_SINGLE;
         endcase
      end
   end
   // ***************************************
   // analog control outputs
   // ***************************************
   logic stop_now; // fault seen this cycle
   assign stop_now = uv_fault || en_fault;
   logic [7:0] pg_cnt_ff; // power-good delay
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pg_cnt_ff <= '0;
      end else if (state_ff != BPSS_RUN || stop_now) begin
         pg_cnt_ff <= '0;
      end else if (pg_cnt_ff != `BPSS_PG_CYCLES) begin
         pg_cnt_ff <= pg_cnt_ff + 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         power_good_out_o <= 1'b0;
         share_current_neg_o <= 1'b0;
         ss_charge_o <= 1'b0;
         ss_discharge_o <= 1'b1;
         comp_discharge_o <= 1'b1;
      end else begin
         // fault clears outputs at once
         power_good_out_o <= !stop_now && pg_cnt_ff == `BPSS_PG_CYCLES;
         share_current_neg_o <= !stop_now && state_ff == BPSS_RUN;
         // soft-start discharge in off and init, comp discharge in off only
         ss_discharge_o <= stop_now || nxt_state == BPSS_OFF || nxt_state == BPSS_INIT;
         comp_discharge_o <= stop_now || nxt_state == BPSS_OFF;
         ss_charge_o <= !stop_now && (nxt_state == BPSS_SOFT || nxt_state == BPSS_RUN);
      end
   end
   // ***************************************
   // pwm latch
   // ***************************************
   // trip sampled via sync: two-cycle lag; off-time granularity is one clk
   always_ff @(posedge clk_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         low_side_gate_o <= 1'b0;
         high_side_drive_o <= 1'b0;
      end else if (stop_now || nxt_state != BPSS_RUN) begin
         low_side_gate_o <= 1'b0;
         high_side_drive_o <= 1'b0;
      end else if (!low_side_gate_o) begin
         low_side_gate_o <= 1'b1; // new cycle on edge
         high_side_drive_o <= 1'b0;
      end else if (sns_ff.peak_trip) begin
         low_side_gate_o <= 1'b0;
         high_side_drive_o <= 1'b1;
      end
   end
   // ***************************************
   // checks
   // ***************************************
   AST_EXCL: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      !(low_side_gate_o && high_side_drive_o)) else $error("gates overlap");
   AST_UV_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      uv_fault |=> !low_side_gate_o && !high_side_drive_o) else $error("switching in uv");
   AST_UV_PG: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      uv_fault |=> !power_good_out_o && ss_discharge_o) else $error("uv outputs");
   AST_EN_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      en_fault |=> !share_current_neg_o && comp_discharge_o && ss_discharge_o)
      else $error("shutdown outputs");
   AST_INIT_DIS: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      state_ff == BPSS_INIT |-> ss_discharge_o && !ss_charge_o) else $error("init discharge");
   AST_SOFT_REF: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      $rose(ss_charge_o) |-> $past(sns_ff.ref_ok)) else $error("charge without ref");
   AST_RUN_START: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      $rose(low_side_gate_o) && $past(state_ff) == BPSS_SOFT |-> $past(sns_ff.start_ok))
      else $error("pwm before start");
   AST_TRIP: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      state_ff == BPSS_RUN && !stop_now && low_side_gate_o && sns_ff.peak_trip
      |=> !low_side_gate_o && high_side_drive_o) else $error("trip ignored");
   AST_EDGE_ON: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
      state_ff == BPSS_RUN && nxt_state == BPSS_RUN && !low_side_gate_o
      |=> low_side_gate_o) else $error("no turn-on");
   COV_START: cover property (@(posedge clk_i) state_ff == BPSS_SOFT ##1 state_ff == BPSS_RUN);
   COV_TRIP: cover property (@(posedge clk_i) low_side_gate_o ##1 high_side_drive_o);
   COV_RESTART: cover property (@(posedge clk_i) state_ff == BPSS_RUN ##1 state_ff == BPSS_OFF);
endmodule

// ===== core/bpss_consts.svh
`ifndef BPSS_CONSTS_SVH
`define BPSS_CONSTS_SVH
// initialization period length in switching clocks
`define BPSS_INIT_CYCLES 8'h10
// width of the init counter
`define BPSS_INIT_W 8
// configuration code field width
`define BPSS_CFG_W 3
// power-good delay after switching starts, in clocks
`define BPSS_PG_CYCLES 8'h40
`endif

// ===== core/bpss_pkg.sv
package bpss_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      BPSS_OFF = 3'b000,
      BPSS_INIT = 3'b001,
      BPSS_SOFT = 3'b010,
      BPSS_RUN = 3'b011
   } bpss_state_type;
   // phase selection decoded from config
   typedef enum logic [1:0] {
      BPSS_PH_DUALQUAD = 2'b00,
      BPSS_PH_SINGLE = 2'b01,
      BPSS_PH_TRIPLE = 2'b10
   } bpss_phase_type;
   // analog status inputs grouped
   typedef struct packed {
      logic drv_ok;
      logic en_on;
      logic en_off;
      logic ref_ok;
      logic ref_low;
      logic start_ok;
      logic peak_trip;
   } bpss_sense_type;
endpackage

// ===== tb/bpss_fet_model.sv
// ****************************************
// switch and sense resistor stand-in
// ****************************************
module bpss_fet_model (
   input wire logic clk_i, // switching clock
   input wire logic low_side_gate_i, // low switch gate
   input wire logic [1:0] delay_i, // random extra on-time
   output logic peak_trip_o // current comparator level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] on_cnt_ff; // cycles the switch conducted
   // current ramps while on, collapses once gate drops
   always_ff @(posedge clk_i) begin
      if (!low_side_gate_i) begin
         on_cnt_ff <= 3'h0;
      end else if (on_cnt_ff != 3'h7) begin
         on_cnt_ff <= on_cnt_ff + 3'h1;
      end
   end
   // trips after one to four cycles, never when off
   assign peak_trip_o = low_side_gate_i && (on_cnt_ff > {1'b0, delay_i});
endmodule

// ===== tb/testbench.sv
module testbench
   import bpss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   bpss_sense_type s = '0; // bench-driven levels
   bpss_sense_type sense;
   logic [2:0] cfg = 3'h0;
   logic trip, lg, hd, pg, sh, ssc, ssd, cd, config_select_pin;
   logic [1:0] ph;
   logic [31:0] seed = 32'h0F441E7C;
   int n_fail = 0;
   int comparisons = 0;
   int nl, nh;
   initial forever #20 clk_i = ~clk_i;
   // trip comes from the switch model
   always_comb begin
      sense = s;
      sense.peak_trip = trip;
   end
   bpss_core dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .sense_i(sense),
      .config_select_pin_i(cfg), .low_side_gate_o(lg), .high_side_drive_o(hd),
      .power_good_out_o(pg), .share_current_neg_o(sh), .ss_charge_o(ssc),
      .ss_discharge_o(ssd), .comp_discharge_o(cd), .ovp_enable_o(config_select_pin), .phase_sel_o(ph));
   bpss_fet_model fet_u (.clk_i(clk_i), .low_side_gate_i(lg), .delay_i(seed[1:0]),
      .peak_trip_o(trip));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // code 11 falls back to single phase
   function automatic logic [1:0] exp_phase(input logic [2:0] c);
      return (c[2:1] == 2'b11) ? 2'b01 : c[2:1];
   endfunction
   task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // full start-up with random config, then run
   task automatic bring_up(input logic [2:0] mix);
      // mix is XORed with random seed bits, so phase code and overvoltage setting still depend on the seed
      cfg = seed[2:0] ^ mix;
      seed = lfsr(seed);
      s = '0;
      s.drv_ok = 1'b1;
      s.en_on = 1'b1;
      s.ref_ok = 1'b1;
      for (int i = 0; i < 40 && ssc !== 1'b1; i++) begin
         chk("init_disch", 4'h1, {3'h0, ssd});
         @(negedge clk_i);
      end
      chk("soft", 4'h2, {2'h0, ssc, ssd});
      chk("cfg", {1'b0, ~cfg[0], exp_phase(cfg)}, {1'b0, config_select_pin, ph});
      repeat (10) @(negedge clk_i);
      chk("no_pwm_early", 4'h0, {2'h0, lg, hd});
      s.start_ok = 1'b1;
      for (int i = 0; i < 10 && lg !== 1'b1; i++) @(negedge clk_i);
      chk("gate_on", 4'h1, {3'h0, lg});
      nl = 0;
      nh = 0;
      repeat (24) begin
         @(negedge clk_i);
         nl += (lg === 1'b1);
         nh += (hd === 1'b1);
      end
      chk("pwm_run", 4'h3, {2'h0, nl > 3, nh > 0});
      for (int i = 0; i < 80 && pg !== 1'b1; i++) @(negedge clk_i);
      chk("pg_share", 4'h3, {2'h0, pg, sh});
   endtask
   // gates must never overlap
   always @(negedge clk_i) begin
      if (lg === 1'b1 && hd === 1'b1) begin
         n_fail++;
         $display("mismatch gate_overlap expected 0 seen 1");
      end
   end
   initial begin
      #(40 * 4000);
      n_fail++;
      tally_and_finish();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      s.en_off = 1'b1; // enable held low until driver ready
      repeat (10) @(negedge clk_i);
      chk("reset_out", 4'h3, {lg, hd, ssd, cd});
      chk("reset_phase", 4'h1, {2'h0, ph});
      nrst_i = 1'b1;
      repeat (4) @(negedge clk_i);
      s = '0;
      s.drv_ok = 1'b1;
      s.en_on = 1'b1;
      repeat (40) @(negedge clk_i);
      chk("no_ref", 4'h1, {2'h0, ssc, ssd});
      // supply, enable, reference faults in turn
      for (int k = 0; k < 4; k++) begin
         bring_up(3'(k * 3));
         s.drv_ok = (k % 3 != 0);
         s.en_on = (k % 3 != 1);
         s.en_off = (k % 3 == 1);
         s.ref_ok = (k % 3 != 2);
         s.ref_low = (k % 3 == 2);
         repeat (4) @(negedge clk_i);
         chk("off_gate", 4'h0, {lg, hd, pg, sh});
         chk("off_disch", 4'h3, {1'b0, ssc, ssd, cd});
         repeat (20) @(negedge clk_i);
         chk("inhibit", 4'h0, {2'h0, lg, hd});
      end
      tally_and_finish();
   end
endmodule
